// ---- design/lp_wake_pkg.sv ----
// constants and types for the low-power wake-up controller
package lp_wake_pkg;
    // wake source indices
    localparam int SRC_TIMER = 0;
    localparam int SRC_RFLD = 1;
    localparam int SRC_TEMP_CL = 2;
    localparam int SRC_TEMP_CT = 3;
    localparam int SRC_GPIO = 4;
    localparam int SRC_PAD_LIM = 5;
    localparam int SRC_CARD = 6;
    localparam int SRC_AUX_INT = 7;
    localparam int SRC_TX_MON = 8;
    localparam int SRC_BUS_LOW = 9;
    localparam int SRC_HOST = 10;
    localparam int NUM_SRC = 11;
    // wake enable reset value: timer, temp sensors, pad limiter, card presence
    localparam logic [10:0] WAKE_EN_RESET = 11'h06D;
    // wake period
    localparam logic [15:0] WAKE_PERIOD_RESET = 16'h012C;
    localparam int CLOCK_MHZ = 250;
    localparam int TIME_MS_NS = 1000000;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int MS_CYCLES = TIME_MS_NS / CLOCK_PERIOD_NS;
    // host two-wire address
    localparam logic [6:0] HOST_ADDR_RESET = 7'h28;
    // scratch
    localparam int SCRATCH_WORDS = 8;
    // power-down bitmap fields
    localparam int PD_GPIO_LSB = 0;
    localparam int PD_GPIO_W = 12;
    localparam int PD_ATX_LSB = 12;
    localparam int PD_AUX_INT = 16;
    localparam int PD_AUX_IO = 17;
    localparam int PD_AUX_CLK = 18;
    localparam int PD_SPI = 19;
    localparam int PD_I2C = 20;
    localparam int PD_CT_CLK = 21;
    localparam int PD_CONTACTLESS_FRONT_END = 22;
    localparam int PD_GATE_STBY = 23;
    localparam int PD_W = 24;
    // refusal reasons
    localparam logic [2:0] REASON_NONE = 3'h0;
    localparam logic [2:0] REASON_BUSY = 3'h1;
    localparam logic [2:0] REASON_NO_USB = 3'h2;
    localparam logic [2:0] REASON_WAKE_PEND = 3'h3;
    localparam logic [2:0] REASON_BOTH = 3'h4;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_STANDBY = 4'h2,
        ST_SUSPEND = 4'h4,
        ST_WAKE = 4'h8
    } lp_state_t;
endpackage : lp_wake_pkg

// ---- design/wake_timer.sv ----
// periodic millisecond wake timer
`timescale 1ns/100ps
`default_nettype none
module wake_timer #(
    parameter int MS_CYC = lp_wake_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // control
    input wire logic run,
    input wire logic [15:0] period_ms,
    // event
    output logic expire
);
    typedef struct packed {
        logic [31:0] sub;
        logic [15:0] ms;
        logic expire;
    } tmr_t;
    tmr_t s_r;
    tmr_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.expire = 1'b0;
        if (!run) begin
            s_nxt.sub = 32'h0;
            s_nxt.ms = 16'h0;
        end else if (s_r.sub >= 32'(MS_CYC - 1)) begin
            s_nxt.sub = 32'h0;
            if (s_r.ms + 16'h1 >= period_ms) begin
                s_nxt.ms = 16'h0;
                s_nxt.expire = 1'b1;
            end else begin
                s_nxt.ms = s_r.ms + 16'h1;
            end
        end else begin
            s_nxt.sub = s_r.sub + 32'h1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expire = s_r.expire;
endmodule : wake_timer
`default_nettype wire

// ---- design/pin_sync.sv ----
// three-stage synchroniser for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // async in, synced out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;
    sync_t s_r;
    sync_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = async_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        for (int i = 0; i < W; i++) begin
            if (s_r.s2[i] == s_r.s3[i]) begin
                s_nxt.q[i] = s_r.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.q;
endmodule : pin_sync
`default_nettype wire

// ---- design/low_power_wakeup_control.sv ----
// low-power state control with wake sources, retained scratch and suspend power-down
// Behaviour
// [R1] standby and suspend; suspend only over USB
// [R2] enabled timer wakes each period expiry
// [R3] period in milliseconds, default 300
// [R4] enabled RF field detect wakes
// [R5] two temperature events, separate enables
// [R6] enabled GPIO activity wakes
// [R7] enabled pad-supply overcurrent wakes standby
// [R8] enabled transmitter-supply overcurrent wakes standby
// [R9] enabled card presence wakes standby
// [R10] enabled auxiliary interrupt wakes standby
// [R11] enabled bus-supply drop wakes standby
// [R12] host wake enable, address default 0x28
// [R13] refuse entry when busy, report reason
// [R14] standby wake restarts; suspend wake continues
// [R15] eight retained 32-bit scratch words
// [R16] suspend applies bitmap, resume restores
// [R17] bits 0-11 pull down GPIO pads
// [R18] bits 12-18 pull down auxiliary pads
// [R19] bit 19 serial, bit 20 two-wire pads
// [R20] bit 21 contact clock, 22 front end
// [R21] bit 23 forces standby gate strength
// [R22] software keeps wake pin bit clear
// [R23] raise supply monitor and limiter events
// [R24] each source gated by own enable
`timescale 1ns/100ps
`default_nettype none
module low_power_wakeup_control #(
    parameter int MS_CYC = lp_wake_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // low-power request
    input wire logic enter_req,
    input wire logic enter_suspend,
    input wire logic usb_host_active,
    input wire logic link_busy,
    // configuration
    input wire logic cfg_we,
    input wire logic [10:0] cfg_wake_en,
    input wire logic [15:0] cfg_wake_period,
    input wire logic [6:0] cfg_host_addr,
    input wire logic [23:0] cfg_pd_bitmap,
    // scratch words
    input wire logic scratch_we,
    input wire logic [2:0] scratch_idx,
    input wire logic [31:0] scratch_wdata,
    output logic [31:0] scratch_rdata,
    // asynchronous wake inputs
    input wire logic rf_field_detect,
    input wire logic contactless_temp_sensor,
    input wire logic contact_temp_sensor,
    input wire logic gpio_wake,
    input wire logic pad_supply_current_limit,
    input wire logic contact_card_presence,
    input wire logic aux_interrupt,
    input wire logic transmitter_supply_monitor,
    input wire logic bus_supply_low,
    input wire logic host_link_wake,
    input wire logic usb_resume,
    // state and status
    output logic in_standby,
    output logic in_suspend,
    output logic enter_done,
    output logic enter_refused,
    output logic [2:0] refuse_reason,
    output logic wake_pulse,
    output logic restart_pulse,
    output logic [10:0] wake_cause,
    output logic [10:0] wake_en,
    output logic [15:0] wake_period_value,
    output logic [6:0] host_addr,
    // suspend power-down controls
    output logic [11:0] gpio_pull_down,
    output logic [3:0] atx_pull_down,
    output logic [2:0] aux_pull_down,
    output logic serial_master_port_pull_down,
    output logic two_wire_master_port_pull_down,
    output logic contact_interface_clk_stop,
    output logic contactless_front_end_off,
    output logic transmitter_gate_strength_standby,
    // asynchronous event outputs
    output logic bus_supply_event,
    output logic pad_limit_event
);
    typedef struct packed {
        lp_wake_pkg::lp_state_t st;
        logic stby;
        logic susp;
        logic [10:0] en;
        logic [15:0] period;
        logic [6:0] addr;
        logic [23:0] bitmap;
        logic [23:0] applied;
        logic from_suspend;
        logic done;
        logic refused;
        logic [2:0] reason;
        logic wake;
        logic restart;
        logic [10:0] cause;
        logic [31:0] rdata;
        logic bus_ev;
        logic pad_ev;
        logic bus_prev;
        logic pad_prev;
    } ctl_t;
    ctl_t s_r;
    ctl_t s_nxt;

    logic [31:0] scratch_r [lp_wake_pkg::SCRATCH_WORDS];
    logic [10:0] async_raw;
    logic [10:0] src;
    logic usb_resume_s;
    logic timer_run;
    logic timer_exp;
    logic [10:0] hits;
    logic low_power;
    logic no_usb;
    logic wake_pend;

    // wake inputs in enable-bit order; bit 0 is the internal timer, filled in after the synchroniser
    assign async_raw[lp_wake_pkg::SRC_TIMER] = 1'b0;
    assign async_raw[lp_wake_pkg::SRC_RFLD] = rf_field_detect; // [R4]
    assign async_raw[lp_wake_pkg::SRC_TEMP_CL] = contactless_temp_sensor; // [R5]
    assign async_raw[lp_wake_pkg::SRC_TEMP_CT] = contact_temp_sensor; // [R5]
    assign async_raw[lp_wake_pkg::SRC_GPIO] = gpio_wake; // [R6]
    assign async_raw[lp_wake_pkg::SRC_PAD_LIM] = pad_supply_current_limit; // [R7]
    assign async_raw[lp_wake_pkg::SRC_CARD] = contact_card_presence; // [R9]
    assign async_raw[lp_wake_pkg::SRC_AUX_INT] = aux_interrupt; // [R10]
    assign async_raw[lp_wake_pkg::SRC_TX_MON] = transmitter_supply_monitor; // [R8]
    assign async_raw[lp_wake_pkg::SRC_BUS_LOW] = bus_supply_low; // [R11]
    assign async_raw[lp_wake_pkg::SRC_HOST] = host_link_wake; // [R12]

    pin_sync #(.W(11)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in(async_raw),
        .sync_out(src)
    );

    pin_sync #(.W(1)) u_sync_usb (
        .clock(clock),
        .resetn(resetn),
        .async_in(usb_resume),
        .sync_out(usb_resume_s)
    );

    assign low_power = s_r.st == lp_wake_pkg::ST_STANDBY || s_r.st == lp_wake_pkg::ST_SUSPEND;
    assign timer_run = low_power && s_r.en[lp_wake_pkg::SRC_TIMER]; // [R2]

    // counts only in a low-power state and starts from zero on each entry
    wake_timer #(.MS_CYC(MS_CYC)) u_timer (
        .clock(clock),
        .resetn(resetn),
        .run(timer_run),
        .period_ms(s_r.period), // [R3]
        .expire(timer_exp)
    );

    // each source passes only under its own enable
    function automatic logic [10:0] gate_src(input logic [10:0] s, input logic [10:0] e, input logic t);
        logic [10:0] v;
        v = {s[10:1], t};
        return v & e;
    endfunction : gate_src

    // [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12]
    assign hits = gate_src(src, s_r.en, timer_exp); // [R24]

    // suspend needs the USB link as host; a pending enabled source would wake at once
    assign no_usb = enter_suspend && !usb_host_active; // [R1]
    assign wake_pend = |hits[lp_wake_pkg::NUM_SRC-1:1]; // [R13]

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.refused = 1'b0;
        s_nxt.wake = 1'b0;
        s_nxt.restart = 1'b0;
        s_nxt.rdata = scratch_r[scratch_idx];
        s_nxt.bus_prev = src[lp_wake_pkg::SRC_BUS_LOW];
        s_nxt.pad_prev = src[lp_wake_pkg::SRC_PAD_LIM];
        s_nxt.bus_ev = src[lp_wake_pkg::SRC_BUS_LOW] && !s_r.bus_prev; // [R23]
        s_nxt.pad_ev = src[lp_wake_pkg::SRC_PAD_LIM] && !s_r.pad_prev; // [R23]
        // config frozen outside run so sources and bitmap cannot shift under a sleeping chip
        if (cfg_we && s_r.st == lp_wake_pkg::ST_RUN) begin
            s_nxt.en = cfg_wake_en;
            s_nxt.period = cfg_wake_period;
            s_nxt.addr = cfg_host_addr;
            s_nxt.bitmap = cfg_pd_bitmap;
        end
        case (s_r.st)
            lp_wake_pkg::ST_RUN: begin
                if (enter_req) begin
                    if (link_busy && no_usb) begin
                        s_nxt.reason = lp_wake_pkg::REASON_BOTH;
                        s_nxt.refused = 1'b1;
                    end else if (link_busy) begin
                        s_nxt.reason = lp_wake_pkg::REASON_BUSY; // [R13]
                        s_nxt.refused = 1'b1;
                    end else if (no_usb) begin
                        s_nxt.reason = lp_wake_pkg::REASON_NO_USB; // [R1]
                        s_nxt.refused = 1'b1;
                    end else if (wake_pend) begin
                        s_nxt.reason = lp_wake_pkg::REASON_WAKE_PEND;
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.reason = lp_wake_pkg::REASON_NONE;
                        s_nxt.cause = 11'h0;
                        s_nxt.done = 1'b1;
                        if (enter_suspend) begin
                            s_nxt.st = lp_wake_pkg::ST_SUSPEND; // [R1]
                            s_nxt.from_suspend = 1'b1;
                            s_nxt.applied = s_r.bitmap; // [R16]
                        end else begin
                            s_nxt.st = lp_wake_pkg::ST_STANDBY; // [R1]
                            s_nxt.from_suspend = 1'b0;
                        end
                    end
                end
            end

            // standby: any enabled source wakes, execution restarts
            lp_wake_pkg::ST_STANDBY: begin
                if (|hits) begin
                    s_nxt.cause = hits;
                    s_nxt.st = lp_wake_pkg::ST_WAKE;
                end
            end

            // suspend: enabled source or host resume; pads return to run settings
            lp_wake_pkg::ST_SUSPEND: begin
                if (|hits || usb_resume_s) begin
                    s_nxt.cause = hits;
                    s_nxt.applied = 24'h0; // [R16]
                    s_nxt.st = lp_wake_pkg::ST_WAKE;
                end
            end

            // one wake cycle so the cause is settled when the pulse shows
            lp_wake_pkg::ST_WAKE: begin
                s_nxt.wake = 1'b1;
                s_nxt.restart = !s_r.from_suspend; // [R14]
                s_nxt.st = lp_wake_pkg::ST_RUN;
            end

            default: begin
                s_nxt.st = lp_wake_pkg::ST_RUN;
            end
        endcase
        // state flags taken from the next state so the outputs come straight from flops
        s_nxt.stby = s_nxt.st == lp_wake_pkg::ST_STANDBY;
        s_nxt.susp = s_nxt.st == lp_wake_pkg::ST_SUSPEND;
    end

    // reset loads the default wake configuration
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.st <= lp_wake_pkg::ST_RUN;
            s_r.en <= lp_wake_pkg::WAKE_EN_RESET;
            s_r.period <= lp_wake_pkg::WAKE_PERIOD_RESET; // [R3]
            s_r.addr <= lp_wake_pkg::HOST_ADDR_RESET; // [R12]
        end else begin
            s_r <= s_nxt;
        end
    end

    // retained scratch words, kept through standby
    always_ff @(posedge clock) begin
        if (scratch_we) begin
            scratch_r[scratch_idx] <= scratch_wdata; // [R15]
        end
    end

    // state and status
    assign in_standby = s_r.stby; // [R1]
    assign in_suspend = s_r.susp; // [R1]
    assign enter_done = s_r.done;
    assign enter_refused = s_r.refused;
    assign refuse_reason = s_r.reason;
    assign wake_pulse = s_r.wake;
    assign restart_pulse = s_r.restart;
    assign wake_cause = s_r.cause;
    assign wake_en = s_r.en;
    assign wake_period_value = s_r.period;
    assign host_addr = s_r.addr;
    assign scratch_rdata = s_r.rdata;

    // suspend power-down controls, zero outside suspend
    assign gpio_pull_down = s_r.applied[lp_wake_pkg::PD_GPIO_LSB +: lp_wake_pkg::PD_GPIO_W]; // [R17]
    assign atx_pull_down = s_r.applied[lp_wake_pkg::PD_ATX_LSB +: 4]; // [R18]
    assign aux_pull_down = s_r.applied[lp_wake_pkg::PD_AUX_CLK:lp_wake_pkg::PD_AUX_INT]; // [R18]
    assign serial_master_port_pull_down = s_r.applied[lp_wake_pkg::PD_SPI]; // [R19]
    assign two_wire_master_port_pull_down = s_r.applied[lp_wake_pkg::PD_I2C]; // [R19]
    assign contact_interface_clk_stop = s_r.applied[lp_wake_pkg::PD_CT_CLK]; // [R20]
    assign contactless_front_end_off = s_r.applied[lp_wake_pkg::PD_CONTACTLESS_FRONT_END]; // [R20]
    assign transmitter_gate_strength_standby = s_r.applied[lp_wake_pkg::PD_GATE_STBY]; // [R21]

    // supply events, raised whatever the enables
    assign bus_supply_event = s_r.bus_ev;
    assign pad_limit_event = s_r.pad_ev;
endmodule : low_power_wakeup_control
`default_nettype wire

// ---- verif/lp_wake_monitor.sv ----
// assertion checker for the low-power wake-up controller
`timescale 1ns/100ps
`default_nettype none
module lp_wake_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // request
    input wire logic enter_req,
    input wire logic enter_suspend,
    input wire logic usb_host_active,
    input wire logic link_busy,
    // status
    input wire logic in_standby,
    input wire logic in_suspend,
    input wire logic enter_done,
    input wire logic enter_refused,
    input wire logic [2:0] refuse_reason,
    input wire logic wake_pulse,
    input wire logic restart_pulse,
    input wire logic [10:0] wake_cause,
    input wire logic [10:0] wake_en,
    input wire logic [11:0] gpio_pull_down,
    input wire logic contactless_front_end_off,
    input wire logic transmitter_gate_strength_standby
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic run;
    assign run = !in_standby && !in_suspend;
    answer_has_request_a: assert property ((enter_done || enter_refused) |-> $past(enter_req && run))
        else $error("answer without request");
    busy_refused_a: assert property (enter_req && link_busy && run |=> enter_refused && !enter_done && run)
        else $error("busy entry not refused");
    suspend_needs_usb_a: assert property (enter_req && enter_suspend && !usb_host_active && run
        |=> !in_suspend) else $error("suspend without usb");
    both_reason_a: assert property (enter_req && enter_suspend && !usb_host_active && link_busy && run
        |=> refuse_reason == lp_wake_pkg::REASON_BOTH) else $error("wrong reason");
    one_state_a: assert property (enter_done |-> in_standby ^ in_suspend)
        else $error("entry without one state");
    standby_restart_a: assert property (restart_pulse |-> wake_pulse && $past(in_standby, 2))
        else $error("restart not from standby");
    suspend_continue_a: assert property (wake_pulse && $past(in_suspend, 2) |-> !restart_pulse)
        else $error("restart after suspend");
    gated_cause_a: assert property (wake_pulse |-> (wake_cause & ~wake_en) == 11'h000)
        else $error("disabled source woke");
    pulldown_idle_a: assert property (!in_suspend |-> gpio_pull_down == 12'h000 && !contactless_front_end_off
        && !transmitter_gate_strength_standby) else $error("power-down outside suspend");
    cover property (enter_done && in_suspend);
    cover property (restart_pulse);
    cover property (enter_refused);
    cover property (wake_pulse && !restart_pulse && wake_cause != 11'h000);
endmodule : lp_wake_monitor
`default_nettype wire

// ---- verif/low_power_wakeup_control_bench.sv ----
// self-checking bench for the low-power wake-up controller
`timescale 1ns/100ps
`default_nettype none
module low_power_wakeup_control_bench;
    localparam int MS = 4;
    logic clock = 1'b0, resetn = 1'b0, enter_req = 1'b0, enter_suspend = 1'b0, usb_host_active = 1'b0;
    logic link_busy = 1'b0, cfg_we = 1'b0, scratch_we = 1'b0, usb_resume = 1'b0;
    logic [10:0] cfg_wake_en = 11'h000, src = 11'h000;
    logic [15:0] cfg_wake_period = 16'h0000;
    logic [6:0] cfg_host_addr = 7'h00;
    logic [23:0] cfg_pd_bitmap = 24'h000000;
    logic [2:0] scratch_idx = 3'h0;
    logic [31:0] scratch_wdata = 32'h00000000;
    logic [31:0] scratch_rdata;
    logic in_standby, in_suspend, enter_done, enter_refused, wake_pulse, restart_pulse;
    logic [2:0] refuse_reason, aux_pull_down;
    logic [10:0] wake_cause, wake_en;
    logic [15:0] wake_period_value;
    logic [6:0] host_addr;
    logic [11:0] gpio_pull_down;
    logic [3:0] atx_pull_down;
    logic serial_master_port_pull_down, two_wire_master_port_pull_down, contact_interface_clk_stop;
    logic contactless_front_end_off, transmitter_gate_strength_standby, bus_supply_event, pad_limit_event;
    logic [23:0] pd;
    int bad_count = 0, total_checks = 0;
    assign pd = {transmitter_gate_strength_standby, contactless_front_end_off, contact_interface_clk_stop,
        two_wire_master_port_pull_down, serial_master_port_pull_down, aux_pull_down, atx_pull_down, gpio_pull_down};
    low_power_wakeup_control #(.MS_CYC(MS)) low_power_wakeup_control_i (.clock, .resetn, .enter_req,
        .enter_suspend, .usb_host_active, .link_busy, .cfg_we, .cfg_wake_en, .cfg_wake_period, .cfg_host_addr,
        .cfg_pd_bitmap, .scratch_we, .scratch_idx, .scratch_wdata, .scratch_rdata, .usb_resume,
        .rf_field_detect(src[1]), .contactless_temp_sensor(src[2]), .contact_temp_sensor(src[3]),
        .gpio_wake(src[4]), .pad_supply_current_limit(src[5]), .contact_card_presence(src[6]),
        .aux_interrupt(src[7]), .transmitter_supply_monitor(src[8]), .bus_supply_low(src[9]),
        .host_link_wake(src[10]), .in_standby, .in_suspend, .enter_done, .enter_refused, .refuse_reason,
        .wake_pulse, .restart_pulse, .wake_cause, .wake_en, .wake_period_value, .host_addr, .gpio_pull_down,
        .atx_pull_down, .aux_pull_down, .serial_master_port_pull_down, .two_wire_master_port_pull_down,
        .contact_interface_clk_stop, .contactless_front_end_off, .transmitter_gate_strength_standby,
        .bus_supply_event, .pad_limit_event);
    always #2 clock = ~clock;
    task automatic end_of_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cfg(input logic [10:0] en, input logic [15:0] per, input logic [23:0] bm);
        @(negedge clock);
        {cfg_wake_en, cfg_wake_period, cfg_pd_bitmap, cfg_host_addr, cfg_we} = {en, per, bm, 7'h11, 1'b1};
        @(negedge clock);
        cfg_we = 1'b0;
    endtask : cfg
    task automatic enter(input logic susp);
        @(negedge clock);
        {enter_req, enter_suspend} = {1'b1, susp};
        @(negedge clock);
        enter_req = 1'b0;
    endtask : enter
    task automatic wait_wake(output int n);
        n = 0;
        while (wake_pulse !== 1'b1) begin
            if (n++ > 200) begin
                bad_count++;
                end_of_test();
            end
            @(negedge clock);
        end
    endtask : wait_wake
    task automatic t_timer();
        int n;
        for (int i = 0; i < 8; i++) begin
            @(negedge clock);
            {scratch_we, scratch_idx, scratch_wdata} = {1'b1, 3'(i), 32'hC0DE0000 + 32'(i)};
        end
        @(negedge clock);
        scratch_we = 1'b0;
        cfg(11'h001, 16'h0002, 24'h000000);
        chk("host_addr", host_addr, 7'h11);
        repeat (2) begin
            enter(1'b0);
            chk("done", {enter_done, in_standby}, 2'h3);
            wait_wake(n);
            chk("timer period", (n >= 2 * MS - 1) && (n <= 2 * MS + 4), 1'b1);
            chk("restart", restart_pulse, 1'b1);
            chk("cause", wake_cause, 11'h001);
        end
        for (int i = 0; i < 8; i++) begin
            scratch_idx = 3'(i);
            @(negedge clock);
            chk("scratch", scratch_rdata, 32'hC0DE0000 + 32'(i));
        end
    endtask : t_timer
    task automatic t_sources();
        int n;
        logic [10:0] en;
        for (int i = 1; i < 11; i++) begin
            en = 11'h001 << i;
            cfg(en, 16'h0001, 24'h000000);
            enter(1'b0);
            src[(i % 10) + 1] = 1'b1;
            repeat (10) @(negedge clock);
            chk("disabled source", in_standby, 1'b1);
            src = 11'h000;
            repeat (6) @(negedge clock);
            src[i] = 1'b1;
            wait_wake(n);
            chk("cause", {wake_cause, restart_pulse}, {en, 1'b1});
            src = 11'h000;
            repeat (6) @(negedge clock);
        end
    endtask : t_sources
    task automatic t_refuse();
        logic [3:0] cs [4] = '{4'b1100, 4'b0010, 4'b1010, 4'b0101};
        logic [2:0] rs [4] = '{lp_wake_pkg::REASON_BUSY, lp_wake_pkg::REASON_NO_USB,
            lp_wake_pkg::REASON_BOTH, lp_wake_pkg::REASON_WAKE_PEND};
        cfg(11'h002, 16'h0001, 24'h000000);
        for (int k = 0; k < 4; k++) begin
            {link_busy, usb_host_active, src[1]} = {cs[k][3:2], cs[k][0]};
            repeat (6) @(negedge clock);
            enter(cs[k][1]);
            chk("refused", {enter_refused, enter_done, in_standby, in_suspend}, 4'h8);
            chk("reason", refuse_reason, rs[k]);
            {link_busy, src} = 12'h000;
            repeat (6) @(negedge clock);
        end
    endtask : t_refuse
    task automatic t_suspend();
        int n;
        cfg(11'h000, 16'h0001, 24'hA5C3F1);
        usb_host_active = 1'b1;
        enter(1'b1);
        chk("suspend", {enter_done, in_suspend}, 2'h3);
        chk("power-down", pd, 24'hA5C3F1);
        usb_resume = 1'b1;
        wait_wake(n);
        usb_resume = 1'b0;
        chk("resume", {restart_pulse, wake_cause, pd}, 36'h0);
        repeat (6) @(negedge clock);
        cfg(11'h010, 16'h0001, 24'hFFFFFE);
        enter(1'b1);
        chk("gpio suspend", {in_suspend, pd}, 25'h1FFFFFE);
        src[4] = 1'b1;
        wait_wake(n);
        src[4] = 1'b0;
        chk("gpio resume", {restart_pulse, wake_cause, pd}, 36'h010000000);
        int_events();
    endtask : t_suspend
    task automatic int_events();
        int nb, np;
        {nb, np} = 0;
        src[9] = 1'b1;
        src[5] = 1'b1;
        repeat (12) begin
            @(negedge clock);
            nb += bus_supply_event;
            np += pad_limit_event;
        end
        chk("supply events", {nb[3:0], np[3:0]}, 8'h11);
        src = 11'h000;
    endtask : int_events
    initial begin
        repeat (20) @(negedge clock);
        resetn = 1'b1;
        chk("reset config", {wake_en, wake_period_value, host_addr}, {11'h06D, 16'h012C, 7'h28});
        t_timer();
        t_sources();
        t_refuse();
        t_suspend();
        end_of_test();
    end
endmodule : low_power_wakeup_control_bench
bind low_power_wakeup_control lp_wake_monitor lp_wake_monitor_i (.clock, .resetn, .enter_req, .enter_suspend,
    .usb_host_active, .link_busy, .in_standby, .in_suspend, .enter_done, .enter_refused, .refuse_reason,
    .wake_pulse, .restart_pulse, .wake_cause, .wake_en, .gpio_pull_down, .contactless_front_end_off,
    .transmitter_gate_strength_standby);
`default_nettype wire
